/* File: rtl/gpio_defines.vh */
// Register map and field constants for the global pin control block
`ifndef GPIO_DEFINES_VH
`define GPIO_DEFINES_VH

`define GPIO_NPINS        30
`define GPIO_AW           4
`define GPIO_ADDR_SEL     4'h0
`define GPIO_ADDR_DIR     4'h1
`define GPIO_ADDR_ODRAIN  4'h2
`define GPIO_ADDR_VALUE   4'h3
`define GPIO_ADDR_READ    4'h4
`define GPIO_RST_SEL      30'h00000000
`define GPIO_RST_DIR      30'h00000000
`define GPIO_RST_ODRAIN   30'h00000000
`define GPIO_RST_VALUE    30'h00000000
`define GPIO_RD_PAD       2'h0

`endif

/* File: rtl/gpio_global.v */
// Global pin control: registers, pin muxing, input read-back
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "gpio_defines.vh"
module gpio_global (
	input  wire        clk,
	input  wire        rst,
	input  wire [3:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	input  wire [29:0] periph_out,
	input  wire [29:0] periph_oe_n,
	input  wire [29:0] pin_in,
	output reg  [29:0] pin_out,
	output reg  [29:0] pin_oe_n,
	output reg  [29:0] periph_in
);
	// Fixed bit map
	// Bit map: 0-7 pulse_out_0a..pulse_out_3b, 8 sync, 9-11 faults 0-2,
	// 12 external_irq_pin, 13 alert, 14 control, 15 data, 16 clock,
	// 17-18 timer_pulse_out_0/1, 19 timer_capture_in, 20-23 serial,
	// 24-27 debug port, 28 converter_trigger_in, 29 fault 3
	reg  [29:0] sel_q;
	reg  [29:0] dir_q;
	reg  [29:0] odrain_q;
	reg  [29:0] value_q;
	wire [29:0] pin_sync;
	wire [29:0] mux_out;
	wire [29:0] mux_oe_n;

	function [31:0] widen;
		input [29:0] v;
		begin
			widen = {`GPIO_RD_PAD, v};
		end
	endfunction

	// Supply, ground, analog pins have no bit
	gpio_sync3 u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  (pin_in),
		.dout (pin_sync)
	);

	gpio_pinmux u_mux (
		.sel         (sel_q),
		.dir         (dir_q),
		.odrain      (odrain_q),
		.value       (value_q),
		.periph_out  (periph_out),
		.periph_oe_n (periph_oe_n),
		.pin_out     (mux_out),
		.pin_oe_n    (mux_oe_n)
	);

	always @(posedge clk) begin
		if (rst) begin
			sel_q    <= `GPIO_RST_SEL;
			dir_q    <= `GPIO_RST_DIR;
			odrain_q <= `GPIO_RST_ODRAIN;
			value_q  <= `GPIO_RST_VALUE;
		end else if (wr) begin
			case (addr)
				`GPIO_ADDR_SEL: begin
					sel_q <= wdata[29:0];
				end
				`GPIO_ADDR_DIR: begin
					dir_q <= wdata[29:0];
				end
				`GPIO_ADDR_ODRAIN: begin
					odrain_q <= wdata[29:0];
				end
				`GPIO_ADDR_VALUE: begin
					value_q <= wdata[29:0];
				end
				default: begin
					sel_q <= sel_q;
				end
			endcase
		end
	end

	// Read data valid only the cycle after the strobe
	always @(posedge clk) begin
		if (rst) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			case (addr)
				`GPIO_ADDR_SEL:    rdata <= widen(sel_q);
				`GPIO_ADDR_DIR:    rdata <= widen(dir_q);
				`GPIO_ADDR_ODRAIN: rdata <= widen(odrain_q);
				`GPIO_ADDR_VALUE:  rdata <= widen(value_q);
				`GPIO_ADDR_READ:   rdata <= widen(pin_sync);
				default:           rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end

	// Registered pins; one cycle latency accepted for clean outputs
	always @(posedge clk) begin
		if (rst) begin
			pin_out   <= 30'h00000000;
			pin_oe_n  <= 30'h3FFFFFFF;
			periph_in <= 30'h00000000;
		end else begin
			pin_out   <= mux_out;
			pin_oe_n  <= mux_oe_n;
			periph_in <= pin_sync;
		end
	end
endmodule

/* File: rtl/gpio_pinmux.v */
// Per-pin choice between peripheral and global control
`timescale 1ns/10ps
module gpio_pinmux (
	input  wire [29:0] sel,
	input  wire [29:0] dir,
	input  wire [29:0] odrain,
	input  wire [29:0] value,
	input  wire [29:0] periph_out,
	input  wire [29:0] periph_oe_n,
	output reg  [29:0] pin_out,
	output reg  [29:0] pin_oe_n
);
	integer i;

	always @* begin
		pin_out  = 30'h00000000;
		pin_oe_n = 30'h00000000;
		for (i = 0; i < 30; i = i + 1) begin
			if (!sel[i]) begin
				pin_out[i]  = periph_out[i];
				pin_oe_n[i] = periph_oe_n[i];
			end else if (odrain[i]) begin
				pin_out[i]  = 1'b0;
				pin_oe_n[i] = ~(dir[i] & ~value[i]);
			end else begin
				pin_out[i]  = value[i];
				pin_oe_n[i] = ~dir[i];
			end
		end
	end
endmodule

/* File: rtl/gpio_sync3.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module gpio_sync3 (
	input  wire        clk,
	input  wire        rst,
	input  wire [29:0] din,
	output reg  [29:0] dout
);
	reg [29:0] s1_q;
	reg [29:0] s2_q;
	reg [29:0] s3_q;

	// First stage feeds only the second
	always @(posedge clk) begin
		if (rst) begin
			s1_q <= 30'h00000000;
			s2_q <= 30'h00000000;
			s3_q <= 30'h00000000;
			dout <= 30'h00000000;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			dout <= (s2_q & s3_q) | (dout & (s2_q | s3_q));
		end
	end
endmodule

/* File: testbench/global_pin_io_control_bench.sv */
// Bench for the global pin block
`timescale 1ns/10ps
module global_pin_io_control_bench;
	logic        clk = 0, rst = 1, wr = 0, rd = 0;
	logic [3:0]  addr = 0;
	logic [31:0] wdata = 0;
	logic [29:0] pout = 30'h12345678, poe = 30'h0F0F00FF, pull = 30'h2AAAAAAA, eoe, eout;
	wire  [31:0] rdata;
	wire  [29:0] pin_in, pin_out, pin_oe_n, periph_in;
	int          num_errors = 0, checks_done = 0, cyc = 0;
	logic [29:0] rows [2][4] = '{'{30'h3FFFFFFF, 30'h0F0F0F0F, 30'h13333333, 30'h2AAAAAAA},
		'{30'h0000FFFF, 30'h3FFFFFFF, 30'h3FFFFFFF, 30'h00FF00FF}};
	always #5 clk = ~clk;
	gpio_global dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .periph_out(pout), .periph_oe_n(poe), .pin_in,
		.pin_out, .pin_oe_n, .periph_in);
	gpic_board board (.pin_out, .pin_oe_n, .pull, .pin_in);
	task chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask
	task bus(input logic w, r, input logic [3:0] a, input logic [29:0] d);
		@(posedge clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= {2'h0, d};
	endtask
	task rreg(input logic [3:0] a, input logic [29:0] e);
		bus(0, 1, a, 0);
		bus(0, 0, a, 0);
		#1 chk("rdata", rdata, {2'h0, e});
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			num_errors++;
			end_sim;
		end
	end
	initial begin
		repeat (9) @(posedge clk);
		#1 chk("oe", pin_oe_n, 30'h3FFFFFFF);
		@(posedge clk) rst <= 0;
		for (logic [3:0] a = 0; a < 4; a++) rreg(a, 0);
		#1 chk("oe", pin_oe_n, poe);
		$display("reset done");
		foreach (rows[r]) begin
			for (logic [3:0] a = 0; a < 4; a++) begin
				bus(1, 0, a, rows[r][a]);
				rreg(a, rows[r][a]);
			end
			repeat (2) @(posedge clk);
			// Unselected bits keep the peripheral
			eoe = rows[r][0] & (~rows[r][1] | rows[r][2] & rows[r][3]) | ~rows[r][0] & poe;
			eout = (rows[r][0] & rows[r][3] & ~rows[r][2] | ~rows[r][0] & pout) & ~eoe;
			#1 chk("oe", pin_oe_n, eoe);
			chk("out", pin_out & ~eoe, eout);
			$display("row done");
		end
		repeat (8) @(posedge clk);
		bus(1, 0, 4'h4, 30'h0);
		rreg(4'h4, eout | pull & eoe);
		chk("periph_in", periph_in, eout | pull & eoe);
		rreg(4'hF, 0);
		bus(1, 0, 4'h0, 30'h0);
		rreg(4'h0, 0);
		@(posedge clk) rst <= 1;
		@(posedge clk) rst <= 0;
		rreg(4'h1, 0);
		$display("edge done");
		end_sim;
	end
endmodule

/* File: testbench/gpic_board.sv */
// Board pads with a pull on each pin
`timescale 1ns/10ps
module gpic_board (
	input  wire [29:0] pin_out,
	input  wire [29:0] pin_oe_n,
	input  wire [29:0] pull,
	output wire [29:0] pin_in
);
	assign pin_in = pin_out & ~pin_oe_n | pull & pin_oe_n;
endmodule

/* File: testbench/gpic_properties.sv */
// Port checker for the global pin block
`timescale 1ns/10ps
module gpic_properties (
	input wire        clk,
	input wire        rst,
	input wire [3:0]  addr,
	input wire [31:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [31:0] rdata,
	input wire [29:0] periph_out,
	input wire [29:0] periph_oe_n,
	input wire [29:0] pin_in,
	input wire [29:0] pin_out,
	input wire [29:0] pin_oe_n,
	input wire [29:0] periph_in
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Long enough to pass the filter
	sequence s_quiet; $stable(pin_in) [*8]; endsequence
	sequence s_wr_rd; wr && addr < 4'h4 ##1 rd && addr == $past(addr); endsequence
	AST_IDLE: assert property (!rd |=> rdata == 32'h0) else $error("idle");
	AST_TOP: assert property (rdata[31:30] == 2'h0) else $error("top");
	AST_UNMAP: assert property (rd && addr > 4'h4 |=> rdata == 32'h0) else $error("unmap");
	AST_RST_OE: assert property (disable iff (1'b0) rst |=> &pin_oe_n) else $error("oe");
	AST_UNSEL: assert property (wr && addr == 4'h0 && wdata[29:0] == 30'h0 |-> ##2
		pin_out == $past(periph_out) && pin_oe_n == $past(periph_oe_n)) else $error("unsel");
	AST_BACK: assert property (s_wr_rd |=> rdata[29:0] == $past(wdata[29:0], 2)) else $error("back");
	AST_SYNC: assert property (s_quiet |-> periph_in == pin_in) else $error("sync");
	AST_PIN: assert property (s_quiet ##0 rd && addr == 4'h4 |=> rdata[29:0] == $past(pin_in)) else $error("pin");
endmodule
bind gpio_global gpic_properties u_chk (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .periph_out, .periph_oe_n,
	.pin_in, .pin_out, .pin_oe_n, .periph_in);
